// >>> hw/mst_timer_defs.svh
// Register offsets, field positions, reset values and timing counts of the MAC symbol timer
`ifndef MST_TIMER_DEFS_SVH
`define MST_TIMER_DEFS_SVH

// ****************************************************************
// Register offsets (byte registers)
// ****************************************************************
`define MST_ADDR_W          4
`define MST_A_CONFIG        4'h0
`define MST_A_DELTA_LO      4'h1
`define MST_A_DELTA_HI      4'h2
`define MST_A_BYTE_CMP      4'h3
`define MST_A_WRAP0         4'h4
`define MST_A_WRAP1         4'h5
`define MST_A_WRAP2         4'h6
`define MST_A_PERCAP_LO     4'h7
`define MST_A_PERCAP_HI     4'h8
`define MST_A_WCAP0         4'h9
`define MST_A_WCAP1         4'ha
`define MST_A_WCAP2         4'hb

// ****************************************************************
// Field positions of the configuration and mask registers
// ****************************************************************
`define MST_B_CMP_FLAG      7
`define MST_B_PER_FLAG      6
`define MST_B_WRAP_FLAG     5
`define MST_B_BYTE_SEL      3
`define MST_B_SYNC          1
`define MST_B_RUN           0
`define MST_B_CMP_MASK      7
`define MST_B_PER_MASK      6
`define MST_B_WRAP_MASK     5

// ****************************************************************
// Reset values
// ****************************************************************
`define MST_RST_SYNC        1'b1

// ****************************************************************
// Widths and timing
// ****************************************************************
`define MST_CNT_W           16
`define MST_WRAP_W          20
`define MST_SLEEP_W         24
`define MST_CALC_W          36
`define MST_OVERHEAD        75
`define MST_RATIO_NUM       40'h0000003d09
`define MST_RATIO_SHIFT     4
`define MST_RATIO_ROUND     40'h0000000008

`endif

// >>> hw/mst_pkg.sv
// Types shared by the MAC symbol timer
`include "mst_timer_defs.svh"
package mst_pkg;

	// ****************************************************************
	// Register bus request carrier
	// ****************************************************************
	typedef struct packed {
		logic [`MST_ADDR_W-1:0] addr;   // Register offset
		logic [7:0]             wdata;  // Write data
		logic                   we;     // Write strobe
		logic                   re;     // Read strobe
	} mst_bus_req_s;

	// ****************************************************************
	// Timer modes
	// ****************************************************************
	typedef enum logic [2:0] {
		MST_IDLE,
		MST_START_WAIT,
		MST_CALC,
		MST_RUN,
		MST_STOP_WAIT
	} mst_state_e;

	// ****************************************************************
	// Whole state of the timer
	// ****************************************************************
	typedef struct packed {
		mst_state_e              state;       // Timer mode
		logic [`MST_CNT_W-1:0]   count;       // Up-counter
		logic [`MST_CNT_W-1:0]   period;      // Programmed period
		logic [`MST_CNT_W-1:0]   delta;       // Delta down-counter
		logic [7:0]              delta_lo;    // Held low delta byte
		logic [7:0]              cmp_val;     // Byte compare value
		logic                    byte_sel;    // Compare byte select
		logic                    sync_en;     // Slow clock alignment
		logic [`MST_WRAP_W-1:0]  wrap;        // Overflow counter
		logic [`MST_WRAP_W-1:0]  wrap_cmp;    // Overflow compare value
		logic [11:0]             wrap_latch;  // Upper overflow bytes for reads
		logic [15:0]             wrap_wr;     // Held lower overflow write bytes
		logic                    wrap_ge_q;   // Previous compare condition
		logic [7:0]              cnt_latch;   // Upper count byte for reads
		logic [`MST_CNT_W-1:0]   cap;         // Captured counter
		logic [`MST_WRAP_W-1:0]  wcap;        // Captured overflow count
		logic                    sfd_q;       // Previous frame delimiter status
		logic                    cmp_flag;    // Compare flag
		logic                    per_flag;    // Period flag
		logic                    wrap_flag;   // Overflow compare flag
		logic                    cmp_mask;    // Compare mask
		logic                    per_mask;    // Period mask
		logic                    wrap_mask;   // Overflow compare mask
		logic [`MST_SLEEP_W-1:0] sleep_store; // Sleep value saved at stop
		logic                    slow_ff1;    // Slow clock sync stage 1
		logic                    slow_ff2;    // Slow clock sync stage 2
		logic                    slow_ff3;    // Edge detect history
		logic [6:0]              calc_cnt;    // Start sequence cycle count
		logic [5:0]              div_cnt;     // Division steps done
		logic [16:0]             div_rem;     // Division remainder
		logic [`MST_CALC_W-1:0]  div_quo;     // Dividend shifting into quotient
		logic [7:0]              rdata;       // Read data
		logic                    irq;         // Interrupt request pulse
		logic                    dma_cmp;     // Compare trigger pulse
		logic                    dma_per;     // Overflow trigger pulse
	} mst_state_s;

endpackage : mst_pkg

// >>> hw/mst_timer.sv
// MAC symbol timer with period, delta stretch, byte compare, overflow count and slow-clock aligned start/stop
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "mst_timer_defs.svh"

module mst_timer #(
	parameter int OVERHEAD_CYCLES = `MST_OVERHEAD  // Aligned start length in cycles
) (
	input  wire logic                    clk_i,                 // System clock
	input  wire logic                    rst_n_i,               // Synchronous reset, active low
	input  wire mst_pkg::mst_bus_req_s   bus_i,                 // Register request
	output logic [7:0]                   rdata_o,               // Read data, cycle after read strobe
	input  wire logic                    sleep_clk_i,           // Slow sleep clock, asynchronous
	input  wire logic [`MST_SLEEP_W-1:0] sleep_count_i,         // Sleep timer value
	input  wire logic                    sfd_i,                 // Radio frame delimiter status
	output logic                         irq_o,                 // Masked event pulse
	output logic                         dma_compare_trigger_o, // Compare event pulse
	output logic                         dma_period_trigger_o   // Overflow event pulse
);
	import mst_pkg::*;

	// ****************************************************************
	// State and working signals
	// ****************************************************************
	mst_state_s              s;          // Registered state
	mst_state_s              next_s;     // Next state
	logic                    slow_edge;  // Slow clock rising strobe
	logic                    running;    // Timer in run mode
	logic                    counting;   // Counter advances this cycle
	logic [`MST_CNT_W-1:0]   cnt_next;   // Value the counter is about to take
	logic                    ovf;        // Overflow event
	logic                    cmp_ev;     // Compare event
	logic                    wrap_ge;    // Overflow count at/above compare
	logic                    wrap_ev;    // Overflow compare event
	logic                    sfd_rise;   // Capture event
	logic                    wr_cfg;     // Configuration write
	logic [2:0]              flag_keep;  // Flag write data, one keeps
	logic [`MST_SLEEP_W:0]   sleep_dif;  // Sleep tick distance
	logic [39:0]             scaled;     // Distance times ratio
	logic [`MST_CALC_W-1:0]  cval;       // Target count before division
	logic [16:0]             rem_sh;     // Shifted remainder

	// Write strobe decode for one offset
	function automatic logic wr_at(input mst_bus_req_s b, input logic [`MST_ADDR_W-1:0] a);
		wr_at = b.we && (b.addr == a);
	endfunction : wr_at

	// Read strobe decode for one offset
	function automatic logic rd_at(input mst_bus_req_s b, input logic [`MST_ADDR_W-1:0] a);
		rd_at = b.re && (b.addr == a);
	endfunction : rd_at

	// ****************************************************************
	// Next state logic
	// ****************************************************************
	// One pass works out every field of the next state. Pulses (read
	// data, request, triggers) default to zero, so each lasts exactly
	// one cycle after the event that raised it. Register writes come
	// after the timer logic, so software wins over a same-cycle update
	// of the same field; the flags are the exception, where the event
	// wins over a clear.
	always_comb begin
		next_s = s;
		next_s.rdata = 8'h00;
		next_s.irq = 1'b0;
		next_s.dma_cmp = 1'b0;
		next_s.dma_per = 1'b0;

		// Slow clock synchroniser and edge strobe
		// The sleep clock comes from another oscillator, so two flops
		// settle it before anything looks at it; the third flop only
		// keeps history so that a rising level becomes a one-cycle strobe.
		// Latency from pin edge to strobe is one to two cycles.
		next_s.slow_ff1 = sleep_clk_i;
		next_s.slow_ff2 = s.slow_ff1;
		next_s.slow_ff3 = s.slow_ff2;
		slow_edge = s.slow_ff2 & ~s.slow_ff3;

		// Run mode covers a pending aligned stop as well: the timer
		// keeps counting until the slow edge arrives.
		// The counter is held while a delta countdown is in progress.
		running = (s.state == MST_RUN) || (s.state == MST_STOP_WAIT);
		counting = running && (s.delta == '0);
		cnt_next = s.count + 16'h0001;
		ovf = counting && (cnt_next >= s.period);
		cmp_ev = counting && ((s.byte_sel ? cnt_next[7:0] : cnt_next[15:8]) >= s.cmp_val);

		// Counter and overflow count
		// The overflow test looks at the value about to be loaded, so a
		// period of P gives exactly P counting cycles between overflows.
		// Subtracting the period rather than loading zero keeps any
		// excess when software shortens the period under a running count.
		if (counting) begin
			next_s.count = ovf ? cnt_next - s.period : cnt_next;
		end
		if (ovf) begin
			next_s.wrap = s.wrap + 20'h00001;
		end

		// Delta countdown at the timer's rate, then rests at zero
		// It does not move while the timer is stopped, so a delta
		// written in idle takes effect once the timer runs.
		if (running && (s.delta != '0)) begin
			next_s.delta = s.delta - 16'h0001;
		end

		// Overflow compare fires when the condition becomes true
		// Edge rather than level: a count that sits at or above the
		// compare value raises one event, not one per cycle. Right after
		// reset both values are zero, so the flag rises at once.
		wrap_ge = s.wrap >= s.wrap_cmp;
		wrap_ev = wrap_ge && !s.wrap_ge_q;
		next_s.wrap_ge_q = wrap_ge;

		// Frame delimiter capture
		// The status input is already on this clock; one flop of
		// history is enough to find its rising edge.
		next_s.sfd_q = sfd_i;
		sfd_rise = sfd_i && !s.sfd_q;
		if (sfd_rise) begin
			next_s.cap = s.count;
			next_s.wcap = s.wrap;
		end

		// Trigger and request pulses
		next_s.dma_cmp = cmp_ev;
		next_s.dma_per = ovf;
		next_s.irq = (ovf && s.per_mask) || (cmp_ev && s.cmp_mask) || (wrap_ev && s.wrap_mask);

		// Start sequence working values
		// The sleep tick distance wraps at the sleep counter width; a
		// zero distance means one full turn of the sleep counter.
		// The ratio has a power-of-two divisor, so the product is
		// rounded to the nearest count by adding half before the shift.
		// The ratio assumes the full-rate system clock.
		sleep_dif = {1'b0, sleep_count_i - s.sleep_store};
		if (sleep_dif == '0) begin
			sleep_dif = {1'b1, {`MST_SLEEP_W{1'b0}}};
		end
		scaled = 40'(sleep_dif) * `MST_RATIO_NUM;
		cval = `MST_CALC_W'((scaled + `MST_RATIO_ROUND) >> `MST_RATIO_SHIFT)
			+ `MST_CALC_W'(s.count) + `MST_CALC_W'(OVERHEAD_CYCLES);
		rem_sh = {s.div_rem[15:0], s.div_quo[`MST_CALC_W-1]};

		// Configuration write decode
		// Flag bits written as zero clear their flag; ones leave it.
		// Without a write all three flags are kept.
		wr_cfg = wr_at(bus_i, `MST_A_CONFIG);
		flag_keep = wr_cfg ? {bus_i.wdata[`MST_B_CMP_FLAG], bus_i.wdata[`MST_B_PER_FLAG],
			bus_i.wdata[`MST_B_WRAP_FLAG]} : 3'b111;

		// Timer mode sequencing
		// Idle to run at once, or idle, start wait, calc, run when
		// aligned. Run to idle at once, or through stop wait when
		// aligned. A run command during the calculation is ignored.
		case (s.state)
			MST_IDLE: begin
				if (wr_cfg && bus_i.wdata[`MST_B_RUN]) begin
					next_s.state = bus_i.wdata[`MST_B_SYNC] ? MST_START_WAIT : MST_RUN;
				end
			end
			MST_START_WAIT: begin
				if (wr_cfg && !bus_i.wdata[`MST_B_RUN]) begin
					next_s.state = MST_IDLE;
				end else if (slow_edge) begin
					next_s.state = MST_CALC;
					next_s.calc_cnt = 7'd1;
					next_s.div_cnt = '0;
					next_s.div_rem = '0;
					next_s.div_quo = cval;
				end
			end
			MST_CALC: begin
				// Restoring division, one quotient bit per cycle; it ends
				// well before the fixed length of the sequence runs out.
				if (s.div_cnt != 6'(`MST_CALC_W)) begin
					next_s.div_cnt = s.div_cnt + 6'd1;
					next_s.div_quo = {s.div_quo[`MST_CALC_W-2:0], 1'b0};
					if (rem_sh >= {1'b0, s.period}) begin
						next_s.div_rem = rem_sh - {1'b0, s.period};
						next_s.div_quo[0] = 1'b1;
					end else begin
						next_s.div_rem = rem_sh;
					end
				end
				next_s.calc_cnt = s.calc_cnt + 7'd1;
				// Load the recomputed values on the last cycle; a zero period
				// leaves the count at zero and the overflow count unchanged.
				if (s.calc_cnt == 7'(OVERHEAD_CYCLES - 1)) begin
					next_s.state = MST_RUN;
					next_s.count = (s.period == '0) ? '0 : s.div_rem[15:0];
					if (s.period != '0) begin
						next_s.wrap = s.wrap + s.div_quo[`MST_WRAP_W-1:0];
					end
				end
			end
			MST_RUN: begin
				if (wr_cfg && !bus_i.wdata[`MST_B_RUN]) begin
					if (bus_i.wdata[`MST_B_SYNC]) begin
						next_s.state = MST_STOP_WAIT;
					end else begin
						next_s.state = MST_IDLE;
						next_s.sleep_store = sleep_count_i;
					end
				end
			end
			MST_STOP_WAIT: begin
				// A new run command cancels the stop; a stop with
				// alignment off ends the wait at once
				if (wr_cfg && bus_i.wdata[`MST_B_RUN]) begin
					next_s.state = MST_RUN;
				end else if (wr_cfg && !bus_i.wdata[`MST_B_SYNC]) begin
					next_s.state = MST_IDLE;
					next_s.sleep_store = sleep_count_i;
				end else if (slow_edge) begin
					next_s.state = MST_IDLE;
					next_s.sleep_store = sleep_count_i;
				end
			end
			default: begin
				next_s.state = MST_IDLE;
			end
		endcase

		// Register writes
		// Values that must change as a whole are held until their last
		// byte arrives; the period and the compare values take effect
		// byte by byte.
		if (wr_cfg) begin
			next_s.byte_sel = bus_i.wdata[`MST_B_BYTE_SEL];
			next_s.sync_en = bus_i.wdata[`MST_B_SYNC];
		end
		if (wr_at(bus_i, `MST_A_DELTA_LO)) begin
			next_s.delta_lo = bus_i.wdata;
		end
		if (wr_at(bus_i, `MST_A_DELTA_HI)) begin
			next_s.delta = {bus_i.wdata, s.delta_lo};
		end
		if (wr_at(bus_i, `MST_A_BYTE_CMP)) begin
			next_s.cmp_val = bus_i.wdata;
		end
		if (wr_at(bus_i, `MST_A_WRAP0)) begin
			next_s.wrap_wr[7:0] = bus_i.wdata;
		end
		if (wr_at(bus_i, `MST_A_WRAP1)) begin
			next_s.wrap_wr[15:8] = bus_i.wdata;
		end
		if (wr_at(bus_i, `MST_A_WRAP2)) begin
			next_s.wrap = {bus_i.wdata[3:0], s.wrap_wr};
		end
		if (wr_at(bus_i, `MST_A_PERCAP_LO)) begin
			next_s.period[7:0] = bus_i.wdata;
		end
		if (wr_at(bus_i, `MST_A_PERCAP_HI)) begin
			next_s.period[15:8] = bus_i.wdata;
		end
		if (wr_at(bus_i, `MST_A_WCAP0)) begin
			next_s.wrap_cmp[7:0] = bus_i.wdata;
		end
		if (wr_at(bus_i, `MST_A_WCAP1)) begin
			next_s.wrap_cmp[15:8] = bus_i.wdata;
		end
		if (wr_at(bus_i, `MST_A_WCAP2)) begin
			next_s.wrap_cmp[19:16] = bus_i.wdata[3:0];
			next_s.cmp_mask = bus_i.wdata[`MST_B_CMP_MASK];
			next_s.per_mask = bus_i.wdata[`MST_B_PER_MASK];
			next_s.wrap_mask = bus_i.wdata[`MST_B_WRAP_MASK];
		end

		// Flags: a write of zero clears, a same-cycle event wins
		next_s.cmp_flag = (s.cmp_flag & flag_keep[2]) | cmp_ev;
		next_s.per_flag = (s.per_flag & flag_keep[1]) | ovf;
		next_s.wrap_flag = (s.wrap_flag & flag_keep[0]) | wrap_ev;

		// Register reads, answered next cycle
		// Reading the low count byte latches the high byte, and reading
		// the lowest overflow byte latches the two upper ones, so a
		// multi-byte read is coherent when the low byte goes first.
		if (bus_i.re) begin
			case (bus_i.addr)
				`MST_A_CONFIG: begin
					next_s.rdata = {s.cmp_flag, s.per_flag, s.wrap_flag, 1'b0,
						s.byte_sel, 1'b0, s.sync_en, running};
				end
				`MST_A_DELTA_LO: begin
					next_s.rdata = s.count[7:0];
				end
				`MST_A_DELTA_HI: begin
					next_s.rdata = s.cnt_latch;
				end
				`MST_A_BYTE_CMP: begin
					next_s.rdata = s.cmp_val;
				end
				`MST_A_WRAP0: begin
					next_s.rdata = s.wrap[7:0];
				end
				`MST_A_WRAP1: begin
					next_s.rdata = s.wrap_latch[7:0];
				end
				`MST_A_WRAP2: begin
					next_s.rdata = {4'h0, s.wrap_latch[11:8]};
				end
				`MST_A_PERCAP_LO: begin
					next_s.rdata = s.cap[7:0];
				end
				`MST_A_PERCAP_HI: begin
					next_s.rdata = s.cap[15:8];
				end
				`MST_A_WCAP0: begin
					next_s.rdata = s.wcap[7:0];
				end
				`MST_A_WCAP1: begin
					next_s.rdata = s.wcap[15:8];
				end
				`MST_A_WCAP2: begin
					next_s.rdata = {s.cmp_mask, s.per_mask, s.wrap_mask, 1'b0, s.wcap[19:16]};
				end
				default: begin
					next_s.rdata = 8'h00;
				end
			endcase
		end
		if (rd_at(bus_i, `MST_A_DELTA_LO)) begin
			next_s.cnt_latch = s.count[15:8];
		end
		if (rd_at(bus_i, `MST_A_WRAP0)) begin
			next_s.wrap_latch = s.wrap[19:8];
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Synchronous reset: the whole state clears, the timer sits idle
	// and alignment starts enabled.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.state <= MST_IDLE;
			s.sync_en <= `MST_RST_SYNC;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// All outputs come straight from flops, so none has a
	// combinational path from the register port.
	assign rdata_o = s.rdata;
	assign irq_o = s.irq;
	assign dma_compare_trigger_o = s.dma_cmp;
	assign dma_period_trigger_o = s.dma_per;

endmodule : mst_timer

// >>> verification/mst_sleep_model.sv
// Sleep timer model: free-running slow clock and its tick count
`timescale 1ns/1ps

module mst_sleep_model #(
	parameter real         HALF_NS = 15258.789, // Half period of the 32.768 kHz clock
	parameter logic [23:0] START   = 24'hfffffd // Starts near the wrap of the count
) (
	output logic        sleep_clk_o,  // Slow clock
	output logic [23:0] sleep_count_o // Tick count
);
	// Free running clock; count steps on each rising edge and wraps at 24 bits
	initial begin
		sleep_clk_o = 1'b0;
		sleep_count_o = START;
		forever begin
			#(HALF_NS) sleep_clk_o = 1'b1;
			sleep_count_o = sleep_count_o + 24'h000001;
			#(HALF_NS) sleep_clk_o = 1'b0;
		end
	end
endmodule : mst_sleep_model

// >>> verification/mst_timer_assertions.sv
// Port-level checker of the MAC symbol timer
`timescale 1ns/1ps

module mst_timer_checker (
	input wire logic                  clk_i,                 // System clock
	input wire logic                  rst_n_i,               // Synchronous reset
	input wire mst_pkg::mst_bus_req_s bus_i,                 // Register request
	input wire logic [7:0]            rdata_o,               // Read data
	input wire logic                  irq_o,                 // Interrupt pulse
	input wire logic                  dma_compare_trigger_o, // Compare pulse
	input wire logic                  dma_period_trigger_o   // Overflow pulse
);
	import mst_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic        started;  // A run command was written
	logic [2:0]  mask_q;   // Mirror of compare, period, wrap masks
	logic [15:0] period_q; // Mirror of the period
	logic [16:0] gap;      // Cycles since last overflow pulse
	logic        gap_ok;   // No register write since that pulse
	wire         cfg_wr = bus_i.we && bus_i.addr == 4'h0;
	// Mirrors of what software wrote; any write spoils the gap measurement
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			started <= 1'b0;
			mask_q <= 3'h0;
			period_q <= 16'h0000;
			gap <= 17'h00000;
			gap_ok <= 1'b0;
		end else begin
			if (cfg_wr && bus_i.wdata[0]) started <= 1'b1;
			if (bus_i.we && bus_i.addr == 4'hb) mask_q <= bus_i.wdata[7:5];
			if (bus_i.we && bus_i.addr == 4'h7) period_q[7:0] <= bus_i.wdata;
			if (bus_i.we && bus_i.addr == 4'h8) period_q[15:8] <= bus_i.wdata;
			gap <= dma_period_trigger_o ? 17'h00001 : gap + 17'h00001;
			if (bus_i.we) gap_ok <= 1'b0;
			else if (dma_period_trigger_o) gap_ok <= 1'b1;
		end
	end
	rst_quiet_a: assert property ($rose(rst_n_i) |-> !irq_o && !dma_period_trigger_o && rdata_o == 8'h00)
		else $error("outputs busy right after reset");
	idle_silent_a: assert property (!started |-> !dma_period_trigger_o && !dma_compare_trigger_o)
		else $error("timer events before any start");
	per_irq_a: assert property (dma_period_trigger_o && mask_q[1] |-> irq_o)
		else $error("unmasked overflow gave no interrupt");
	cmp_irq_a: assert property (dma_compare_trigger_o && mask_q[2] |-> irq_o)
		else $error("unmasked compare gave no interrupt");
	irq_masked_a: assert property (irq_o |-> mask_q != 3'h0)
		else $error("interrupt with all masks off");
	stop_now_a: assert property (cfg_wr && bus_i.wdata[1:0] == 2'b00 |-> ##2 !dma_period_trigger_o [*8])
		else $error("overflow after immediate stop");
	delta_hold_a: assert property (bus_i.we && bus_i.addr == 4'h2 && bus_i.wdata != 8'h00
		|-> ##2 !dma_period_trigger_o [*8])
		else $error("overflow while delta holds the counter");
	period_gap_a: assert property (dma_period_trigger_o && gap_ok |-> gap == {1'b0, period_q})
		else $error("overflow spacing differs from period");
	per_pulse_a: assert property (dma_period_trigger_o && period_q > 16'h0001 |=> !dma_period_trigger_o)
		else $error("overflow trigger longer than one cycle");
	cover property (dma_period_trigger_o && irq_o);
	cover property (dma_compare_trigger_o);
	cover property (gap_ok && dma_period_trigger_o);
endmodule : mst_timer_checker

bind mst_timer mst_timer_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.irq_o(irq_o), .dma_compare_trigger_o(dma_compare_trigger_o), .dma_period_trigger_o(dma_period_trigger_o));

// >>> verification/tb.sv
// Self-checking testbench of the MAC symbol timer
`timescale 1ns/1ps

module tb;
	import mst_pkg::*;
	logic              clk_i, rst_n_i, sfd, irq, dma_cmp, dma_per, sl_clk;
	logic              slow_q = 1'b0;
	mst_bus_req_s      bus;
	logic [7:0]        rdata, d;
	logic [23:0]       sl_cnt;
	logic [15:0]       c;
	logic [19:0]       o;
	logic [31:0]       ta, tb_, tc, e;
	int                num_errors, n_compared, cyc, n_slow, t_slow, t_run, n_irq, n_cmp, n_per;
	int                t0, t1, np, ni, nc, s1, nd, i;

	mst_timer #(.OVERHEAD_CYCLES(75)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
		.sleep_clk_i(sl_clk), .sleep_count_i(sl_cnt), .sfd_i(sfd), .irq_o(irq),
		.dma_compare_trigger_o(dma_cmp), .dma_period_trigger_o(dma_per));
	mst_sleep_model u_sleep (.sleep_clk_o(sl_clk), .sleep_count_o(sl_cnt));

	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Cycle count, slow edges, event pulses and hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		slow_q <= sl_clk;
		if (sl_clk && !slow_q) begin
			n_slow <= n_slow + 1;
			t_slow <= cyc;
		end
		n_irq <= n_irq + (irq === 1'b1);
		n_cmp <= n_cmp + (dma_cmp === 1'b1);
		n_per <= n_per + (dma_per === 1'b1);
		if (cyc == 40000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic summarize();
		if (num_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
		n_compared++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			num_errors++;
			$display("FAIL %s expected %0h..%0h seen %0h", nm, lo, hi, got);
		end
	endtask : chk
	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		bus.addr <= a;
		bus.wdata <= v;
		bus.we <= 1'b1;
		@(posedge clk_i);
		bus.we <= 1'b0;
		#1;
	endtask : wr
	// One-cycle read strobe; data stands in the next cycle only
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_i);
		bus.addr <= a;
		bus.re <= 1'b1;
		@(posedge clk_i);
		bus.re <= 1'b0;
		#1;
		v = rdata;
	endtask : rd
	task automatic rchk(input logic [3:0] a, input logic [7:0] x);
		logic [7:0] v;
		rd(a, v);
		chk($sformatf("reg %0h", a), {24'h0, x}, {24'h0, x}, {24'h0, v});
	endtask : rchk
	// Count and overflow count, lowest bytes first; period is 16
	task automatic get_tot(output logic [31:0] t);
		logic [7:0] b0, b1, b2, b3, b4;
		rd(4'h1, b0);
		rd(4'h2, b1);
		rd(4'h4, b2);
		rd(4'h5, b3);
		rd(4'h6, b4);
		c = {b1, b0};
		o = {b4[3:0], b3, b2};
		t = {8'h00, o, 4'h0} + {16'h0000, c};
	endtask : get_tot
	task automatic poll(input logic v);
		logic [7:0] r;
		for (int k = 0; k < 5000; k++) begin
			rd(4'h0, r);
			if (r[0] === v) break;
		end
		t_run = cyc;
		chk("run status", {31'h0, v}, {31'h0, v}, {31'h0, r[0]});
	endtask : poll

	initial begin
		rst_n_i = 1'b0;
		bus = '0;
		sfd = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Count and compare are both zero, so the wrap compare flag is up
		rchk(4'h0, 8'h22);
		get_tot(ta);
		chk("reset count", 0, 0, ta);
		wr(4'h7, 8'h10);
		wr(4'h8, 8'h00);
		wr(4'h3, 8'h0c);
		wr(4'h9, 8'h00);
		wr(4'ha, 8'h01);
		wr(4'hb, 8'h00);
		wr(4'h0, 8'h08);
		np = n_per;
		ni = n_irq;
		nc = n_cmp;
		wr(4'h0, 8'h09);
		t0 = cyc;
		repeat (100) @(posedge clk_i);
		wr(4'h0, 8'he8);
		t1 = cyc;
		get_tot(tb_);
		chk("wrapped count", 0, 15, c);
		chk("elapsed", t1 - t0 - 1, t1 - t0 + 1, tb_);
		chk("overflow pulses", o, o, n_per - np);
		chk("compare pulses", 1, 200, n_cmp - nc);
		chk("masked irq", 0, 0, n_irq - ni);
		rchk(4'h0, 8'hc8);
		wr(4'h0, 8'h08);
		rchk(4'h0, 8'h08);
		wr(4'hb, 8'h40);
		np = n_per;
		ni = n_irq;
		nc = n_cmp;
		wr(4'h0, 8'h01);
		t0 = cyc;
		wr(4'h1, 8'h00);
		wr(4'h2, 8'h01);
		repeat (300) @(posedge clk_i);
		wr(4'h0, 8'he0);
		t1 = cyc;
		get_tot(tc);
		chk("delta", tb_ + t1 - t0 - 258, tb_ + t1 - t0 - 255, tc);
		chk("unmasked irq", n_per - np, n_per - np, n_irq - ni);
		chk("high byte", 0, 0, n_cmp - nc);
		rchk(4'h0, 8'h40);
		wr(4'h4, 8'h34);
		wr(4'h5, 8'h12);
		rchk(4'h4, o[7:0]);
		wr(4'h6, 8'h05);
		rchk(4'h4, 8'h34);
		wr(4'h4, 8'h00);
		wr(4'h5, 8'h00);
		wr(4'h6, 8'h0a);
		rchk(4'h5, 8'h12);
		rchk(4'h6, 8'h05);
		rchk(4'h0, 8'h60);
		wr(4'hc, 8'hff);
		rchk(4'hc, 8'h00);
		@(posedge clk_i);
		sfd <= 1'b1;
		repeat (3) @(posedge clk_i);
		sfd <= 1'b0;
		rchk(4'h7, c[7:0]);
		rchk(4'h8, c[15:8]);
		rchk(4'h9, 8'h00);
		rchk(4'hb, 8'h4a);
		wr(4'h0, 8'h03);
		poll(1'b1);
		chk("aligned start", 77, 83, t_run - t_slow);
		wr(4'h0, 8'h02);
		rd(4'h0, d);
		chk("stop pending", 1, 1, d[0]);
		poll(1'b0);
		chk("aligned stop", 2, 8, t_run - t_slow);
		s1 = n_slow;
		get_tot(ta);
		for (i = 0; i < 9000 && n_slow < s1 + 2; i++) @(posedge clk_i);
		repeat (20) @(posedge clk_i);
		wr(4'h0, 8'h03);
		poll(1'b1);
		nd = n_slow - s1;
		wr(4'h0, 8'h00);
		t1 = cyc;
		get_tot(tb_);
		e = (nd * 15625 + 8) / 16 + 75 + t1 - t_run;
		chk("recomputed", e - 2, e + 3, (tb_ - ta) & 32'h00ffffff);
		summarize();
	end
endmodule : tb
